// file: common/eim_pkg.sv
// constants shared by the peripheral interrupt mask block
// assumes an apb master with 32-bit data and byte addresses on a 12-bit paddr
package eim_pkg;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int NUM_SRC = 8;
    localparam int CA_REQ_W = 6;
    localparam int SI_REQ_W = 4;
    // register indexes; byte address is four times the index
    localparam logic [7:0] MASK_IDX = 8'hE6;
    localparam logic [7:0] STAT_IDX = 8'hE7;
    localparam logic [7:0] CLR_IDX = 8'hE8;
    localparam logic [7:0] IEN_IDX = 8'hE9;
    localparam logic [7:0] RAW_IDX = 8'hEA;
    localparam logic [APB_AW-1:0] MASK_ADDR = APB_AW'({MASK_IDX, 2'b00});
    localparam logic [APB_AW-1:0] STAT_ADDR = APB_AW'({STAT_IDX, 2'b00});
    localparam logic [APB_AW-1:0] CLR_ADDR = APB_AW'({CLR_IDX, 2'b00});
    localparam logic [APB_AW-1:0] IEN_ADDR = APB_AW'({IEN_IDX, 2'b00});
    localparam logic [APB_AW-1:0] RAW_ADDR = APB_AW'({RAW_IDX, 2'b00});
    // bit positions in the mask, status, clear and enable registers
    localparam int BIT_CMP_ONE_RISE = 7;
    localparam int BIT_CMP_ONE_FALL = 6;
    localparam int BIT_CMP_ZERO_RISE = 5;
    localparam int BIT_CMP_ZERO_FALL = 4;
    localparam int BIT_COUNTER_ARRAY = 3;
    localparam int BIT_CONV_WINDOW = 2;
    localparam int BIT_TWOWIRE_BUS = 1;
    localparam int BIT_SERIAL_IFACE = 0;
    // raw register layout: flags in the low byte, forwarded requests above
    localparam int RAW_FLAG_LSB = 0;
    localparam int RAW_REQ_LSB = 8;
    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [APB_DW-1:0] RDATA_RST = 32'h0000_0000;
endpackage

// file: rtl/eim_src_gate.sv
// one source channel: mask gate, forwarded request flop and sticky event bit
// assumes flag and enable are synchronous to core_clk
`timescale 1ns/1ps
module eim_src_gate import eim_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // source side
    input wire logic flag,
    input wire logic enable,
    // software clear of the sticky bit
    input wire logic clr,
    // results
    output logic req,
    output logic sticky
);
    typedef struct packed {
        logic req;
        logic sticky;
    } eim_gate_t;

    eim_gate_t q;
    eim_gate_t next_q;
    logic rise;

    // a new forwarded request counts as an event; set beats a same-cycle clear
    always_comb begin
        next_q = q;
        next_q.req = flag & enable;
        rise = next_q.req & ~q.req;
        next_q.sticky = rise | (q.sticky & ~clr);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign req = q.req;
    assign sticky = q.sticky;
endmodule

// file: rtl/eim_apb_port.sv
// apb slave front end: answers every access after one access cycle
// assumes the register file supplies decode hit and read data from paddr
`timescale 1ns/1ps
module eim_apb_port import eim_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    output logic pready,
    output logic pslverr,
    output logic [APB_DW-1:0] prdata,
    // register file side
    input wire logic hit,
    input wire logic [APB_DW-1:0] rdata,
    output logic wr_en
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [APB_DW-1:0] prdata;
    } eim_port_t;

    eim_port_t q;
    eim_port_t next_q;

    // read data is captured in the setup cycle so it leaves a flop
    always_comb begin
        next_q = q;
        if (psel && !penable) begin
            next_q.pready = 1'b1;
            next_q.pslverr = ~hit;
            next_q.prdata = (hit && !pwrite) ? rdata : RDATA_RST;
        end else if (psel && penable && q.pready) begin
            next_q.pready = 1'b0;
            next_q.pslverr = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // a write lands only on the completing edge, and never on an error
    assign wr_en = psel & penable & q.pready & pwrite & hit;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;
endmodule

// file: rtl/eim_top.sv
// peripheral interrupt mask: eight gated sources, apb registers, one irq line
// assumes peripheral flags are synchronous to core_clk and held until served
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module eim_top import eim_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [APB_DW-1:0] prdata,
    // peripheral flags
    input wire logic cmp_one_rise_flag,
    input wire logic cmp_one_fall_flag,
    input wire logic cmp_zero_rise_flag,
    input wire logic cmp_zero_fall_flag,
    input wire logic [CA_REQ_W-1:0] counter_array_req,
    input wire logic converter_window_flag,
    input wire logic twowire_bus_flag,
    input wire logic [SI_REQ_W-1:0] serial_iface_req,
    // forwarded requests to the core
    output logic cmp_one_rise_req,
    output logic cmp_one_fall_req,
    output logic cmp_zero_rise_req,
    output logic cmp_zero_fall_req,
    output logic counter_array_irq,
    output logic converter_window_irq,
    output logic twowire_bus_irq,
    output logic serial_iface_irq,
    // summary interrupt
    output logic irq
);
    typedef struct packed {
        logic [NUM_SRC-1:0] mask;
        logic [NUM_SRC-1:0] ien;
        logic irq;
        logic mask_written;
    } eim_state_t;

    eim_state_t q;
    eim_state_t next_q;
    logic [NUM_SRC-1:0] src_flag;
    logic [NUM_SRC-1:0] src_req;
    logic [NUM_SRC-1:0] status;
    logic [NUM_SRC-1:0] clr;
    logic hit;
    logic wr_en;
    logic [APB_DW-1:0] rdata;

    // gather sources; grouped peripherals share one mask bit each
    always_comb begin
        src_flag = '0;
        src_flag[BIT_CMP_ONE_RISE] = cmp_one_rise_flag;
        src_flag[BIT_CMP_ONE_FALL] = cmp_one_fall_flag;
        src_flag[BIT_CMP_ZERO_RISE] = cmp_zero_rise_flag;
        src_flag[BIT_CMP_ZERO_FALL] = cmp_zero_fall_flag;
        src_flag[BIT_COUNTER_ARRAY] = |counter_array_req;
        src_flag[BIT_CONV_WINDOW] = converter_window_flag;
        src_flag[BIT_TWOWIRE_BUS] = twowire_bus_flag;
        src_flag[BIT_SERIAL_IFACE] = |serial_iface_req;
    end

    // address decode; only aligned words of the five registers answer
    always_comb begin
        unique case (paddr)
            MASK_ADDR,
            STAT_ADDR,
            CLR_ADDR,
            IEN_ADDR,
            RAW_ADDR: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // read mux; the clear register is write-only and reads zero
    always_comb begin
        rdata = '0;
        unique case (paddr)
            MASK_ADDR: rdata[NUM_SRC-1:0] = q.mask;
            STAT_ADDR: rdata[NUM_SRC-1:0] = status;
            IEN_ADDR: rdata[NUM_SRC-1:0] = q.ien;
            RAW_ADDR: begin
                rdata[RAW_FLAG_LSB +: NUM_SRC] = src_flag;
                rdata[RAW_REQ_LSB +: NUM_SRC] = src_req;
            end
            default: rdata = '0;
        endcase
    end

    // write-one-to-clear pulses for the sticky status bits
    assign clr = (wr_en && paddr == CLR_ADDR) ? pwdata[NUM_SRC-1:0] : '0;

    // register updates and the summary interrupt level
    always_comb begin
        next_q = q;
        if (wr_en && paddr == MASK_ADDR) begin
            next_q.mask = pwdata[NUM_SRC-1:0];
            next_q.mask_written = 1'b1;
        end
        if (wr_en && paddr == IEN_ADDR) begin
            next_q.ien = pwdata[NUM_SRC-1:0];
        end
        next_q.irq = |(status & q.ien);
    end

    // mask resets to all-clear so no source fires before software opts in
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q.mask <= MASK_RST;
            q.ien <= IEN_RST;
            q.irq <= 1'b0;
            q.mask_written <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // one gate per source; each adds a cycle of latency so outputs leave flops
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        eim_src_gate u_gate (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .flag(src_flag[i]),
            .enable(q.mask[i]),
            .clr(clr[i]),
            .req(src_req[i]),
            .sticky(status[i])
        );
    end

    eim_apb_port u_port (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .hit(hit),
        .rdata(rdata),
        .wr_en(wr_en)
    );

    // forwarded requests to the core
    assign cmp_one_rise_req = src_req[BIT_CMP_ONE_RISE];
    assign cmp_one_fall_req = src_req[BIT_CMP_ONE_FALL];
    assign cmp_zero_rise_req = src_req[BIT_CMP_ZERO_RISE];
    assign cmp_zero_fall_req = src_req[BIT_CMP_ZERO_FALL];
    assign counter_array_irq = src_req[BIT_COUNTER_ARRAY];
    assign converter_window_irq = src_req[BIT_CONV_WINDOW];
    assign twowire_bus_irq = src_req[BIT_TWOWIRE_BUS];
    assign serial_iface_irq = src_req[BIT_SERIAL_IFACE];
    assign irq = q.irq;

    // comparator one rising edge: flag and mask together reach the core next cycle
    property p_cmp_one_rise;
        @(posedge core_clk) disable iff (!arst_n)
        (cmp_one_rise_flag && q.mask[BIT_CMP_ONE_RISE]) |=> cmp_one_rise_req;
    endproperty
    a_cmp_one_rise: assert property (p_cmp_one_rise)
        else $error("comparator one rising request not forwarded");

    property p_cmp_one_rise_off;
        @(posedge core_clk) disable iff (!arst_n)
        !q.mask[BIT_CMP_ONE_RISE] |=> !cmp_one_rise_req;
    endproperty
    a_cmp_one_rise_off: assert property (p_cmp_one_rise_off)
        else $error("comparator one rising request leaked while masked");

    // comparator one falling edge follows its flag only while enabled
    property p_cmp_one_fall;
        @(posedge core_clk) disable iff (!arst_n)
        ##1 cmp_one_fall_req == $past(cmp_one_fall_flag & q.mask[BIT_CMP_ONE_FALL]);
    endproperty
    a_cmp_one_fall: assert property (p_cmp_one_fall)
        else $error("comparator one falling request wrong");

    // comparator zero rising: a masked period of two cycles keeps the output low
    property p_cmp_zero_rise;
        @(posedge core_clk) disable iff (!arst_n)
        (!q.mask[BIT_CMP_ZERO_RISE]) [*2] |-> !cmp_zero_rise_req;
    endproperty
    a_cmp_zero_rise: assert property (p_cmp_zero_rise)
        else $error("comparator zero rising request leaked");

    property p_cmp_zero_rise_on;
        @(posedge core_clk) disable iff (!arst_n)
        (cmp_zero_rise_flag && q.mask[BIT_CMP_ZERO_RISE]) |=> cmp_zero_rise_req;
    endproperty
    a_cmp_zero_rise_on: assert property (p_cmp_zero_rise_on)
        else $error("comparator zero rising request lost");

    // comparator zero falling: a held request drops one cycle after masking
    property p_cmp_zero_fall;
        @(posedge core_clk) disable iff (!arst_n)
        !q.mask[BIT_CMP_ZERO_FALL] |=> !cmp_zero_fall_req;
    endproperty
    a_cmp_zero_fall: assert property (p_cmp_zero_fall)
        else $error("comparator zero falling request leaked while masked");

    // a forwarded request only follows an enabled flag of the cycle before
    property p_cmp_zero_fall_gate;
        @(posedge core_clk) disable iff (!arst_n)
        cmp_zero_fall_req |-> $past(cmp_zero_fall_flag) && $past(q.mask[BIT_CMP_ZERO_FALL]);
    endproperty
    a_cmp_zero_fall_gate: assert property (p_cmp_zero_fall_gate)
        else $error("comparator zero falling request without enabled flag");

    // any counter array line forwards one grouped request
    property p_counter_array;
        @(posedge core_clk) disable iff (!arst_n)
        (|counter_array_req && q.mask[BIT_COUNTER_ARRAY]) |=> counter_array_irq;
    endproperty
    a_counter_array: assert property (p_counter_array)
        else $error("counter array request not forwarded");

    property p_counter_array_off;
        @(posedge core_clk) disable iff (!arst_n)
        !q.mask[BIT_COUNTER_ARRAY] |=> !counter_array_irq;
    endproperty
    a_counter_array_off: assert property (p_counter_array_off)
        else $error("counter array request leaked while masked");

    // converter window passes only while its bit is one
    property p_conv_window;
        @(posedge core_clk) disable iff (!arst_n)
        converter_window_irq |-> $past(q.mask[BIT_CONV_WINDOW]) && $past(converter_window_flag);
    endproperty
    a_conv_window: assert property (p_conv_window)
        else $error("converter window request without enable");

    // two-wire bus event flag, checked over a held flag
    property p_twowire_bus;
        @(posedge core_clk) disable iff (!arst_n)
        (twowire_bus_flag && q.mask[BIT_TWOWIRE_BUS]) [*2] |-> twowire_bus_irq;
    endproperty
    a_twowire_bus: assert property (p_twowire_bus)
        else $error("two-wire bus request not forwarded");

    property p_twowire_bus_off;
        @(posedge core_clk) disable iff (!arst_n)
        !q.mask[BIT_TWOWIRE_BUS] |=> !twowire_bus_irq;
    endproperty
    a_twowire_bus_off: assert property (p_twowire_bus_off)
        else $error("two-wire bus request leaked while masked");

    // serial interface: any of its lines, gated by bit 0
    property p_serial_iface;
        @(posedge core_clk) disable iff (!arst_n)
        ##1 serial_iface_irq == ($past(|serial_iface_req) && $past(q.mask[BIT_SERIAL_IFACE]));
    endproperty
    a_serial_iface: assert property (p_serial_iface)
        else $error("serial interface request wrong");

    // mask stays clear from reset until software first writes it
    property p_mask_reset;
        @(posedge core_clk) disable iff (!arst_n)
        !q.mask_written |-> (q.mask == MASK_RST) && (src_req == '0);
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask not clear before first write");

    // a completed mask write shows up in the mask one cycle later
    property p_mask_write;
        @(posedge core_clk) disable iff (!arst_n)
        (wr_en && paddr == MASK_ADDR) |=> q.mask == $past(pwdata[NUM_SRC-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not applied");

    // summary interrupt follows enabled sticky bits by one cycle
    property p_irq;
        @(posedge core_clk) disable iff (!arst_n)
        ##1 irq == $past(|(status & q.ien));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output does not track enabled status");

    // every setup cycle is answered in the following cycle
    property p_apb_ready;
        @(posedge core_clk) disable iff (!arst_n)
        (psel && !penable) |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("apb access not answered");

    // converter window flag with its bit set reaches the core next cycle
    property p_conv_window_on;
        @(posedge core_clk) disable iff (!arst_n)
        (converter_window_flag && q.mask[BIT_CONV_WINDOW]) |=> converter_window_irq;
    endproperty
    a_conv_window_on: assert property (p_conv_window_on)
        else $error("converter window request lost");

    // a rising forwarded request always leaves its sticky bit set, even under a clear
    property p_status_set;
        @(posedge core_clk) disable iff (!arst_n)
        ((src_req & ~$past(src_req)) & ~status) == '0;
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("status bit missed a request rise");

    // a clear empties its bits unless a new request rose at the same edge
    property p_status_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (clr != '0) |=> (status & $past(clr) & ~(src_req & ~$past(src_req))) == '0;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status bit survived its clear");

    // pready stands for one access cycle only, so a master never sees a stale answer
    property p_apb_done;
        @(posedge core_clk) disable iff (!arst_n)
        (psel && penable && pready) |=> !pready;
    endproperty
    a_apb_done: assert property (p_apb_done)
        else $error("apb ready held past the access cycle");

    // unmapped or misaligned accesses answer with an error and zero data
    property p_apb_err;
        @(posedge core_clk) disable iff (!arst_n)
        (psel && !penable && !hit) |=> pslverr && (prdata == '0);
    endproperty
    a_apb_err: assert property (p_apb_err)
        else $error("refused access not flagged");

    // the mask only moves on a completed mask write
    property p_mask_hold;
        @(posedge core_clk) disable iff (!arst_n)
        !(wr_en && paddr == MASK_ADDR) |=> $stable(q.mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask changed without a write");
endmodule

// file: dv/eim_periph_model.sv
// peripheral flag sources and core-side request sampler around the mask block
// assumes commands from the bench change just after core_clk rising edges
`timescale 1ns/1ps
module eim_periph_model import eim_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // bench commands
    input wire logic [7:0] src_cmd,
    input wire logic [CA_REQ_W-1:0] ca_pat,
    input wire logic [SI_REQ_W-1:0] si_pat,
    // flags toward the block
    output logic [7:0] flags,
    output logic [CA_REQ_W-1:0] ca_req,
    output logic [SI_REQ_W-1:0] si_req,
    // forwarded requests from the block, bit order as the mask
    input wire logic [7:0] req_in,
    output logic [7:0] req_vec
);
    // peripheral flags are synchronous, so they launch from a flop like real sources
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= 8'h00;
            ca_req <= '0;
            si_req <= '0;
        end else begin
            flags <= src_cmd;
            ca_req <= src_cmd[BIT_COUNTER_ARRAY] ? ca_pat : '0;
            si_req <= src_cmd[BIT_SERIAL_IFACE] ? si_pat : '0;
        end
    end
    // the core only sees the requests as they stand at its clock edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_vec <= 8'h00;
        end else begin
            req_vec <= req_in;
        end
    end
endmodule

// file: dv/eim_top_tb.sv
// self-checking bench for the peripheral interrupt mask block over apb
// assumes a one-access-cycle apb slave and registered request outputs
`timescale 1ns/1ps
module eim_top_tb import eim_pkg::*;;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0;
    logic pready, pslverr, irq;
    logic [APB_DW-1:0] prdata;
    logic [7:0] src_cmd = 8'h00, flags, req_vec;
    wire [7:0] req_in;
    logic [CA_REQ_W-1:0] ca_pat = '0, ca_req;
    logic [SI_REQ_W-1:0] si_pat = '0, si_req;
    logic [APB_DW-1:0] rd;
    logic er;
    int errors = 0;
    int tests_run = 0;
    // 100 MHz
    always #5 core_clk = ~core_clk;
    eim_periph_model eim_periph_model_inst (.core_clk(core_clk), .arst_n(arst_n), .src_cmd(src_cmd),
        .ca_pat(ca_pat), .si_pat(si_pat), .flags(flags), .ca_req(ca_req), .si_req(si_req),
        .req_in(req_in), .req_vec(req_vec));
    eim_top eim_top_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .cmp_one_rise_flag(flags[7]), .cmp_one_fall_flag(flags[6]),
        .cmp_zero_rise_flag(flags[5]), .cmp_zero_fall_flag(flags[4]), .counter_array_req(ca_req),
        .converter_window_flag(flags[2]), .twowire_bus_flag(flags[1]), .serial_iface_req(si_req),
        .cmp_one_rise_req(req_in[7]), .cmp_one_fall_req(req_in[6]), .cmp_zero_rise_req(req_in[5]),
        .cmp_zero_fall_req(req_in[4]), .counter_array_irq(req_in[3]), .converter_window_irq(req_in[2]),
        .twowire_bus_irq(req_in[1]), .serial_iface_irq(req_in[0]), .irq(irq));
    task automatic end_sim();
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one apb transfer; request held until pready is sampled high, bounded wait
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            $display("[ERR] %0t apb wait ran out", $time);
            errors++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_word(input logic [APB_DW-1:0] got, input logic [APB_DW-1:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
            errors++;
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %0t %s got %b want %b", $time, m, got, exp);
            errors++;
        end
    endtask
    // read a register and compare data and error flag
    task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] exp, input logic e, input string m);
        apb(1'b0, a, '0);
        chk_word(rd, exp, m);
        chk_bit(er, e, m);
    endtask
    // main sequence
    initial begin
        int i;
        logic [7:0] b;
        cyc(16);
        arst_n <= 1'b1;
        rd_chk(MASK_ADDR, 32'h0000_0000, 1'b0, "mask reset");
        rd_chk(IEN_ADDR, 32'h0000_0000, 1'b0, "enable reset");
        rd_chk(STAT_ADDR, 32'h0000_0000, 1'b0, "status reset");
        $display("test reset done");
        // each source against its own mask bit and against all the others
        for (i = 0; i < NUM_SRC; i++) begin
            b = 8'h01 << i;
            apb(1'b1, MASK_ADDR, 32'h0000_0000);
            src_cmd <= b;
            ca_pat <= CA_REQ_W'(1 << (i % CA_REQ_W));
            si_pat <= SI_REQ_W'(1 << (i % SI_REQ_W));
            cyc(4);
            chk_word(32'(req_vec), 32'h0, "masked source");
            apb(1'b1, MASK_ADDR, 32'(b));
            cyc(3);
            chk_word(32'(req_vec), 32'(b), "enabled source");
            apb(1'b1, MASK_ADDR, 32'(~b));
            cyc(3);
            chk_word(32'(req_vec), 32'h0, "other bits set");
        end
        // every line of the grouped sources is gated by one bit
        apb(1'b1, MASK_ADDR, 32'h0000_0009);
        src_cmd <= 8'h09;
        for (i = 0; i < CA_REQ_W; i++) begin
            ca_pat <= CA_REQ_W'(1 << i);
            si_pat <= SI_REQ_W'(1 << (i % SI_REQ_W));
            cyc(4);
            chk_word(32'(req_vec), 32'h9, "group line");
        end
        $display("test gating done");
        // sticky status, enable and clear
        src_cmd <= 8'h06;
        apb(1'b1, MASK_ADDR, 32'hFFFF_FF06);
        apb(1'b1, CLR_ADDR, 32'h0000_00FF);
        rd_chk(MASK_ADDR, 32'h0000_0006, 1'b0, "mask upper bits");
        rd_chk(RAW_ADDR, 32'h0000_0606, 1'b0, "raw flags and requests");
        apb(1'b1, MASK_ADDR, 32'h0000_0000);
        apb(1'b1, CLR_ADDR, 32'h0000_00FF);
        rd_chk(STAT_ADDR, 32'h0000_0000, 1'b0, "status cleared");
        apb(1'b1, IEN_ADDR, 32'h0000_0002);
        apb(1'b1, MASK_ADDR, 32'h0000_0006);
        cyc(3);
        chk_bit(irq, 1'b1, "irq raised");
        rd_chk(STAT_ADDR, 32'h0000_0006, 1'b0, "status set");
        apb(1'b1, CLR_ADDR, 32'h0000_0002);
        cyc(2);
        chk_bit(irq, 1'b0, "irq after clear");
        apb(1'b1, IEN_ADDR, 32'h0000_0004);
        cyc(2);
        chk_bit(irq, 1'b1, "irq other enable");
        src_cmd <= 8'h00;
        rd_chk(STAT_ADDR, 32'h0000_0004, 1'b0, "status sticky");
        apb(1'b1, IEN_ADDR, 32'h0000_0000);
        cyc(2);
        chk_bit(irq, 1'b0, "irq masked");
        $display("test interrupt done");
        // refused accesses, and an ignored write to the read-only status register
        rd_chk(12'h004, 32'h0000_0000, 1'b1, "unmapped read");
        rd_chk(MASK_ADDR + 12'h001, 32'h0000_0000, 1'b1, "misaligned read");
        apb(1'b1, STAT_ADDR, 32'h0000_00FF);
        rd_chk(STAT_ADDR, 32'h0000_0004, 1'b0, "status read only");
        // mid-run reset clears the mask again
        apb(1'b1, MASK_ADDR, 32'h0000_00FF);
        src_cmd <= 8'hFF;
        @(posedge core_clk);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        cyc(3);
        chk_word(32'(req_vec), 32'h0, "requests after reset");
        rd_chk(MASK_ADDR, 32'h0000_0000, 1'b0, "mask after reset");
        $display("test errors and reset done");
        end_sim();
    end
endmodule
